//--- src/dsb_pkg.sv
// dsb_pkg: shared constants, register map and helpers of the dsp subsystem map and boot control
package dsb_pkg;

    // ---------------------------------------------------------------
    // memory sizes in kilobytes
    // ---------------------------------------------------------------
    localparam logic [7:0] L1P_RAM_KB = 8'd32;
    localparam logic [7:0] L1D_RAM_KB = 8'd32;
    localparam logic [7:0] L2_RAM_KB = 8'd128;
    localparam logic [7:0] L1D_CACHE_MAX_KB = 8'd16;
    localparam logic [7:0] CACHE_STEP_KB = 8'd4;
    localparam logic [7:0] HOST_RAM_KB = 8'd32;
    localparam logic [7:0] HOST_ROM_KB = 8'd8;

    // ---------------------------------------------------------------
    // cache size encodings: 0 = none, n = 4 KB shifted left by n-1
    // ---------------------------------------------------------------
    localparam logic [2:0] L1P_ENC_MAX = 3'h4;
    localparam logic [2:0] L1D_ENC_MAX = 3'h3;
    localparam logic [2:0] L2_ENC_MAX = 3'h6;

    // ---------------------------------------------------------------
    // external address windows
    // ---------------------------------------------------------------
    localparam logic [31:0] DDR_BASE = 32'h8000_0000;
    localparam logic [31:0] DDR_LAST = 32'h8FFF_FFFF;
    localparam logic [31:0] ACS_BASE = 32'h4200_0000;
    localparam logic [31:0] ACS_LAST = 32'h49FF_FFFF;
    localparam int ACS_REGIONS = 4;
    localparam int ACS_SHIFT = 25;
    localparam logic [31:0] HOST_RAM_BASE = 32'h1000_0000;
    localparam logic [31:0] HOST_ROM_BASE = 32'h1001_0000;
    localparam logic [31:0] CTRL_BASE = 32'h2000_0000;
    localparam logic [31:0] CTRL_LAST = 32'h2000_FFFF;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CACHE_CFG = 8'h00;
    localparam logic [7:0] OFS_HOST2DSP = 8'h04;
    localparam logic [7:0] OFS_SS_CTRL = 8'h08;
    localparam logic [7:0] OFS_SS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_CACHE_KB = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CFG_L1P_LSB = 0;
    localparam int CFG_L1D_LSB = 4;
    localparam int CFG_L2_LSB = 8;
    localparam int H2D_NMI_BIT = 4;
    localparam int CTL_CLK_EN = 0;
    localparam int CTL_RUN = 1;
    localparam int CTL_BOOT_GO = 2;
    localparam int CTL_PLL_BYPASS = 3;
    localparam int CTL_STATIC_PD = 4;
    localparam int CTL_CPU_SLEEP = 5;
    localparam int CTL_MEM_SLEEP = 6;
    localparam int CTL_WIDTH = 7;
    localparam int IRQ_DSP2HOST = 0;
    localparam int IRQ_POWERDOWN = 1;
    localparam int IRQ_ACC_DENIED = 2;
    localparam int IRQ_WIDTH = 3;

    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [2:0] CACHE_ENC_RESET = 3'h0;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 7'h00;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;
    localparam logic [1:0] SAMPLE_CYCLES = 2'h3;

    typedef enum logic [3:0] {
        ST_SAMPLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_RUN = 4'b0100,
        ST_SLEEP = 4'b1000
    } dsb_state_t;

    // encoding accepted only up to the memory's own largest cache size
    function automatic logic enc_ok(input logic [2:0] enc, input logic [2:0] enc_max);
        enc_ok = (enc <= enc_max);
    endfunction

    function automatic logic [7:0] enc_to_kb(input logic [2:0] enc);
        logic [7:0] kb;
        kb = 8'h00;
        if (enc != 3'h0) begin
            kb = CACHE_STEP_KB << (enc - 3'h1);
        end
        enc_to_kb = kb;
    endfunction

    function automatic logic in_window(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

endpackage

//--- src/dsb_sync.sv
// dsb_sync: two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ns
module dsb_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule // dsb_sync

//--- src/dsb_addr_decode.sv
// dsb_addr_decode: combinational window decode of signal-processor external accesses
`timescale 1ns/1ns
module dsb_addr_decode (
    // access
    input wire logic [31:0] addr,
    input wire logic is_prog,
    // window hits
    output logic ddr_hit,
    output logic [3:0] cs_hit,
    output logic host_ram_hit,
    output logic host_rom_hit,
    output logic denied
);
    import dsb_pkg::*;

    logic [31:0] ram_last;
    logic [31:0] rom_last;
    logic [31:0] cs_ofs;
    logic acs_win;
    logic ctrl_win;
    logic [1:0] cs_idx;

    assign ram_last = HOST_RAM_BASE + ({24'h00_0000, HOST_RAM_KB} << 10) - 32'h1;
    assign rom_last = HOST_ROM_BASE + ({24'h00_0000, HOST_ROM_KB} << 10) - 32'h1;
    assign cs_ofs = addr - ACS_BASE;
    assign cs_idx = cs_ofs[ACS_SHIFT+1:ACS_SHIFT];
    assign ddr_hit = in_window(addr, DDR_BASE, DDR_LAST);
    // chip selects serve data accesses only
    assign acs_win = in_window(addr, ACS_BASE, ACS_LAST) && !is_prog;
    assign cs_hit = acs_win ? (4'h1 << cs_idx) : 4'h0;
    assign host_ram_hit = in_window(addr, HOST_RAM_BASE, ram_last);
    assign host_rom_hit = in_window(addr, HOST_ROM_BASE, rom_last);
    // controller registers are host-only space
    assign ctrl_win = in_window(addr, CTRL_BASE, CTRL_LAST);
    assign denied = ctrl_win || !(ddr_hit || acs_win || host_ram_hit || host_rom_hit);
endmodule // dsb_addr_decode

//--- src/dsb_top.sv
// dsb_top: map, interrupt, clock and boot control around the signal-processor subsystem
// Notes on behaviour
// - program RAM 32 KB, cache 0/4/8/16/32 KB
// - data RAM 32 KB, cache 0/4/8/16 KB
// - level-2 RAM 128 KB, cache up to 128
// - DDR window 8000_0000 to 8FFF_FFFF routed
// - four 32 MB chip-select windows, data only
// - controller registers reachable by host only
// - host RAM and ROM reachable by processor
// - host raises four interrupts plus NMI
// - processor raises one interrupt to host
// - boot pin latched at reset, 0=host
// - self-boot starts right after reset
// - host registers boot, clock, reset control
// - clock from PLL, or pin in bypass
// - static sleep for CPU, memories, clock off
// - software command enters static power-down one cycle after the write, from run state only
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module dsb_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic HOST_IRQ,
    // boot strap pin
    input wire logic BOOT_SELECT_PIN,
    // signal-processor access port
    input wire logic DSP_REQ,
    input wire logic DSP_IS_PROG,
    input wire logic [31:0] DSP_ADDR,
    input wire logic DSP_HOST_INT_REQ,
    output logic DDR_SEL,
    output logic [3:0] ASYNC_CHIP_SELECT,
    output logic HOST_RAM_SEL,
    output logic HOST_ROM_SEL,
    output logic DSP_ACC_DENIED,
    // interrupts toward the processor
    output logic [3:0] DSP_GEN_INT,
    output logic DSP_NMI,
    // cache partitioning
    output logic [2:0] L1P_CACHE_CFG,
    output logic [2:0] L1D_CACHE_CFG,
    output logic [2:0] L2_CACHE_CFG,
    // subsystem clock, reset, boot and sleep
    output logic DSP_CLK_EN,
    output logic CLK_SRC_BYPASS,
    output logic DSP_RESET_N,
    output logic DSP_BOOT_START,
    output logic BOOT_MODE_SELF,
    output logic CPU_SLEEP,
    output logic MEM_SLEEP
);
    import dsb_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic boot_pin_s;
    dsb_state_t state_q, state_d;
    logic [1:0] sample_cnt_q;
    logic boot_self_q;
    logic [2:0] l1p_q, l1d_q, l2_q;
    logic [CTL_WIDTH-1:0] ctl_q, ctl_d;
    logic [IRQ_WIDTH-1:0] irq_stat_q, irq_stat_d, irq_mask_q;
    logic [4:0] h2d_q;
    logic pready_q, pslverr_q, irq_q;
    logic [31:0] prdata_q;
    logic ddr_q, ram_q, rom_q, denied_q;
    logic [3:0] cs_q;
    logic dsp_rst_n_q, boot_start_q, clk_en_q, cpu_slp_q, mem_slp_q;
    logic ddr_hit, ram_hit, rom_hit, acc_denied;
    logic [3:0] cs_hit;
    logic access, wr_en, rd_phase;
    logic [7:0] ofs;
    logic sel_cfg, sel_h2d, sel_ctl, sel_sts, sel_ist, sel_imk, sel_ckb;
    logic mapped;
    logic [31:0] rd_mux;
    logic [2:0] wr_l1p, wr_l1d, wr_l2;
    logic sample_done, enter_run, pd_event, denied_event;

    // ---------------------------------------------------------------
    // boot pin synchroniser
    // ---------------------------------------------------------------
    dsb_sync u_boot_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .din(BOOT_SELECT_PIN),
        .dout(boot_pin_s)
    );

    // ---------------------------------------------------------------
    // window decode of processor accesses
    // ---------------------------------------------------------------
    dsb_addr_decode u_decode (
        .addr(DSP_ADDR),
        .is_prog(DSP_IS_PROG),
        .ddr_hit(ddr_hit),
        .cs_hit(cs_hit),
        .host_ram_hit(ram_hit),
        .host_rom_hit(rom_hit),
        .denied(acc_denied)
    );

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // one wait state: pready comes from a flop, so access cycle 2 completes
    assign access = PSEL && PENABLE;
    assign rd_phase = access && !pready_q;
    assign wr_en = access && pready_q && PWRITE && mapped;
    assign ofs = PADDR[7:0];
    assign sel_cfg = (ofs == OFS_CACHE_CFG);
    assign sel_h2d = (ofs == OFS_HOST2DSP);
    assign sel_ctl = (ofs == OFS_SS_CTRL);
    assign sel_sts = (ofs == OFS_SS_STATUS);
    assign sel_ist = (ofs == OFS_IRQ_STATUS);
    assign sel_imk = (ofs == OFS_IRQ_MASK);
    assign sel_ckb = (ofs == OFS_CACHE_KB);
    assign mapped = (PADDR[31:8] == 24'h00_0000) &&
                    (sel_cfg || sel_h2d || sel_ctl || sel_sts || sel_ist || sel_imk || sel_ckb);

    assign rd_mux = sel_cfg ? {21'h00_0000, l2_q, 1'b0, l1d_q, 1'b0, l1p_q} :
                    sel_ctl ? {25'h000_0000, ctl_q} :
                    sel_sts ? {24'h00_0000, state_q, 1'b0, dsp_rst_n_q, ctl_q[CTL_CLK_EN], boot_self_q} :
                    sel_ist ? {29'h0000_0000, irq_stat_q} :
                    sel_imk ? {29'h0000_0000, irq_mask_q} :
                    sel_ckb ? {8'h00, enc_to_kb(l2_q), enc_to_kb(l1d_q), enc_to_kb(l1p_q)} :
                    32'h0000_0000;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= rd_phase;
            pslverr_q <= rd_phase && !mapped;
            prdata_q <= (rd_phase && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // cache partitioning
    // ---------------------------------------------------------------
    assign wr_l1p = PWDATA[CFG_L1P_LSB+:3];
    assign wr_l1d = PWDATA[CFG_L1D_LSB+:3];
    assign wr_l2 = PWDATA[CFG_L2_LSB+:3];

    // each field checked on its own, so one bad field spoils only itself
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            l1p_q <= CACHE_ENC_RESET;
            l1d_q <= CACHE_ENC_RESET;
            l2_q <= CACHE_ENC_RESET;
        end else if (wr_en && sel_cfg) begin
            if (enc_ok(wr_l1p, L1P_ENC_MAX)) begin
                l1p_q <= wr_l1p;
            end
            if (enc_ok(wr_l1d, L1D_ENC_MAX)) begin
                l1d_q <= wr_l1d;
            end
            if (enc_ok(wr_l2, L2_ENC_MAX)) begin
                l2_q <= wr_l2;
            end
        end
    end

    // ---------------------------------------------------------------
    // boot sampling and subsystem state
    // ---------------------------------------------------------------
    // the strap is taken a few cycles after release, once the synchroniser has settled
    assign sample_done = (state_q == ST_SAMPLE) && (sample_cnt_q == SAMPLE_CYCLES);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sample_cnt_q <= 2'h0;
            boot_self_q <= 1'b0;
        end else if (state_q == ST_SAMPLE) begin
            sample_cnt_q <= sample_cnt_q + 2'h1;
            if (sample_done) begin
                boot_self_q <= boot_pin_s;
            end
        end
    end

    always_comb begin
        ctl_d = ctl_q;
        if (wr_en && sel_ctl) begin
            ctl_d = PWDATA[CTL_WIDTH-1:0];
        end
        ctl_d[CTL_BOOT_GO] = wr_en && sel_ctl && PWDATA[CTL_BOOT_GO];
        if (sample_done && boot_pin_s) begin
            // self-boot: hardware grants clock and reset release on its own
            ctl_d[CTL_CLK_EN] = 1'b1;
            ctl_d[CTL_RUN] = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SAMPLE: begin
                if (sample_done) begin
                    state_d = boot_pin_s ? ST_RUN : ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ctl_q[CTL_RUN]) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctl_q[CTL_RUN]) begin
                    state_d = ST_HOLD;
                end else if (ctl_q[CTL_STATIC_PD]) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!ctl_q[CTL_RUN]) begin
                    state_d = ST_HOLD;
                end else if (!ctl_q[CTL_STATIC_PD]) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_SAMPLE;
            end
        endcase
    end

    assign enter_run = (state_d == ST_RUN) && ((state_q == ST_SAMPLE) || (state_q == ST_HOLD));
    assign pd_event = (state_d == ST_SLEEP) && (state_q != ST_SLEEP);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_SAMPLE;
            ctl_q <= CTL_RESET;
            dsp_rst_n_q <= 1'b0;
            boot_start_q <= 1'b0;
            clk_en_q <= 1'b0;
            cpu_slp_q <= 1'b0;
            mem_slp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctl_q <= ctl_d;
            dsp_rst_n_q <= (state_d == ST_RUN) || (state_d == ST_SLEEP);
            boot_start_q <= enter_run || ctl_d[CTL_BOOT_GO];
            // static power-down stops the clock as well as the enable bit does
            clk_en_q <= ctl_d[CTL_CLK_EN] && (state_d != ST_SLEEP);
            cpu_slp_q <= ctl_d[CTL_CPU_SLEEP] || (state_d == ST_SLEEP);
            mem_slp_q <= ctl_d[CTL_MEM_SLEEP] || (state_d == ST_SLEEP);
        end
    end

    // ---------------------------------------------------------------
    // processor access routing
    // ---------------------------------------------------------------
    assign denied_event = DSP_REQ && acc_denied;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ddr_q <= 1'b0;
            cs_q <= 4'h0;
            ram_q <= 1'b0;
            rom_q <= 1'b0;
            denied_q <= 1'b0;
        end else begin
            ddr_q <= DSP_REQ && ddr_hit;
            cs_q <= DSP_REQ ? cs_hit : 4'h0;
            ram_q <= DSP_REQ && ram_hit;
            rom_q <= DSP_REQ && rom_hit;
            denied_q <= denied_event;
        end
    end

    // ---------------------------------------------------------------
    // interrupts toward host and processor
    // ---------------------------------------------------------------
    // a new event in the clearing cycle survives the write-one-to-clear
    always_comb begin
        irq_stat_d = (wr_en && sel_ist) ? (irq_stat_q & ~PWDATA[IRQ_WIDTH-1:0]) : irq_stat_q;
        irq_stat_d[IRQ_DSP2HOST] = irq_stat_d[IRQ_DSP2HOST] || DSP_HOST_INT_REQ;
        irq_stat_d[IRQ_POWERDOWN] = irq_stat_d[IRQ_POWERDOWN] || pd_event;
        irq_stat_d[IRQ_ACC_DENIED] = irq_stat_d[IRQ_ACC_DENIED] || denied_event;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
            irq_q <= 1'b0;
            h2d_q <= 5'h00;
        end else begin
            irq_stat_q <= irq_stat_d;
            h2d_q <= (wr_en && sel_h2d) ? PWDATA[H2D_NMI_BIT:0] : 5'h00;
            if (wr_en && sel_imk) begin
                irq_mask_q <= PWDATA[IRQ_WIDTH-1:0];
            end
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign HOST_IRQ = irq_q;
    assign DDR_SEL = ddr_q;
    assign ASYNC_CHIP_SELECT = cs_q;
    assign HOST_RAM_SEL = ram_q;
    assign HOST_ROM_SEL = rom_q;
    assign DSP_ACC_DENIED = denied_q;
    assign DSP_GEN_INT = h2d_q[3:0];
    assign DSP_NMI = h2d_q[H2D_NMI_BIT];
    assign L1P_CACHE_CFG = l1p_q;
    assign L1D_CACHE_CFG = l1d_q;
    assign L2_CACHE_CFG = l2_q;
    assign DSP_CLK_EN = clk_en_q;
    assign CLK_SRC_BYPASS = ctl_q[CTL_PLL_BYPASS];
    assign DSP_RESET_N = dsp_rst_n_q;
    assign DSP_BOOT_START = boot_start_q;
    assign BOOT_MODE_SELF = boot_self_q;
    assign CPU_SLEEP = cpu_slp_q;
    assign MEM_SLEEP = mem_slp_q;
endmodule // dsb_top

//--- testbench/dsb_dsp_mdl.sv
// dsb_dsp_mdl: processor-side requester feeding the access port and host interrupt
`timescale 1ns/1ns
module dsb_dsp_mdl (
    // clock
    input wire logic clk,
    // access and interrupt request
    output logic req,
    output logic is_prog,
    output logic [31:0] addr,
    output logic int_req
);
    initial begin
        req = 1'b0;
        is_prog = 1'b0;
        addr = 32'h0;
        int_req = 1'b0;
    end
    // released lines show the inverse so a stale value never passes for a live one
    task automatic access(input logic [31:0] a, input logic pg);
        @(posedge clk);
        req <= 1'b1;
        addr <= a;
        is_prog <= pg;
        @(posedge clk);
        req <= 1'b0;
        addr <= ~a;
        is_prog <= ~pg;
    endtask
    task automatic raise_int();
        @(posedge clk);
        int_req <= 1'b1;
        @(posedge clk);
        int_req <= 1'b0;
    endtask
endmodule // dsb_dsp_mdl

//--- testbench/dsb_top_chk.sv
// dsb_top_chk: port-level assertions for the map and boot control block
`timescale 1ns/1ns
module dsb_top_chk (
    // clock, reset and apb
    input wire logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY,
    input wire logic [31:0] PADDR, PWDATA,
    // boot
    input wire logic BOOT_MODE_SELF, DSP_RESET_N, DSP_BOOT_START,
    // access port
    input wire logic DSP_REQ, DSP_IS_PROG, DDR_SEL, HOST_RAM_SEL, DSP_ACC_DENIED, DSP_NMI,
    input wire logic [31:0] DSP_ADDR,
    input wire logic [3:0] ASYNC_CHIP_SELECT, DSP_GEN_INT,
    input wire logic [2:0] L1P_CACHE_CFG, L1D_CACHE_CFG, L2_CACHE_CFG
);
    logic [31:0] cs_ofs;
    logic wr_done;
    assign cs_ofs = DSP_ADDR - 32'h4200_0000;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    ddr_route_a: assert property (DSP_REQ && DSP_ADDR[31:28] == 4'h8 |=> DDR_SEL && !DSP_ACC_DENIED)
        else $error("ddr window not routed");
    cs_map_a: assert property (DSP_REQ && !DSP_IS_PROG && DSP_ADDR >= 32'h4200_0000 && DSP_ADDR <= 32'h49FF_FFFF
        |=> ASYNC_CHIP_SELECT == 4'h1 << $past(cs_ofs[26:25]))
        else $error("wrong chip select");
    cs_prog_a: assert property (DSP_REQ && DSP_IS_PROG |=> ASYNC_CHIP_SELECT == 4'h0)
        else $error("program fetch reached chip select");
    ctrl_block_a: assert property (DSP_REQ && DSP_ADDR[31:16] == 16'h2000 |=> DSP_ACC_DENIED && !DDR_SEL)
        else $error("controller registers reachable");
    host_ram_a: assert property (DSP_REQ && DSP_ADDR[31:15] == 17'h2000 |=> HOST_RAM_SEL)
        else $error("host ram not selected");
    int_pulse_a: assert property (wr_done && PADDR == 32'h4 |=> {DSP_NMI, DSP_GEN_INT} == $past(PWDATA[4:0]))
        else $error("interrupt pulses differ from write");
    cfg_range_a: assert property (L1P_CACHE_CFG <= 3'h4 && L1D_CACHE_CFG <= 3'h3 && L2_CACHE_CFG <= 3'h6)
        else $error("cache size out of range");
    cfg_hold_a: assert property (!(wr_done && PADDR == 32'h0)
        |=> $stable({L1P_CACHE_CFG, L1D_CACHE_CFG, L2_CACHE_CFG}))
        else $error("cache setting changed without write");
    self_boot_a: assert property ($rose(BOOT_MODE_SELF) |-> ##[0:2] (DSP_RESET_N && DSP_BOOT_START))
        else $error("self boot did not start");
    mode_latch_a: assert property ($changed(BOOT_MODE_SELF) |-> !$past(DSP_RESET_N))
        else $error("boot mode changed while running");
    cover property (DSP_REQ && DSP_ADDR[31:28] == 4'h8);
    cover property ($rose(BOOT_MODE_SELF));
    cover property (DSP_NMI);
endmodule // dsb_top_chk
bind dsb_top dsb_top_chk chk_u (.*);

//--- testbench/dsb_top_tb.sv
// dsb_top_tb: self-checking bench for the map and boot control block
`timescale 1ns/1ns
module dsb_top_tb;
    import dsb_pkg::*;
    logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, HOST_IRQ, BOOT_SELECT_PIN, DSP_REQ, DSP_IS_PROG;
    logic DSP_HOST_INT_REQ, DDR_SEL, HOST_RAM_SEL, HOST_ROM_SEL, DSP_ACC_DENIED, DSP_NMI, DSP_CLK_EN;
    logic CLK_SRC_BYPASS, DSP_RESET_N, DSP_BOOT_START, BOOT_MODE_SELF, CPU_SLEEP, MEM_SLEEP, e;
    logic [31:0] PADDR, PWDATA, PRDATA, DSP_ADDR, r, v;
    logic [31:0] seed = 32'h58;
    logic [3:0] ASYNC_CHIP_SELECT, DSP_GEN_INT;
    logic [2:0] L1P_CACHE_CFG, L1D_CACHE_CFG, L2_CACHE_CFG, p, d, l;
    logic [31:0] cor [8] = '{32'h8FFF_FFFF, 32'h9000_0000, 32'h49FF_FFFF, 32'h4A00_0000,
        32'h4400_0010, 32'h1000_7FFF, 32'h1000_8000, 32'h2000_0004};
    int bad_count = 0;
    int compares = 0;
    dsb_top dut_u (.*);
    dsb_dsp_mdl far_u (.clk(CLK), .req(DSP_REQ), .is_prog(DSP_IS_PROG), .addr(DSP_ADDR), .int_req(DSP_HOST_INT_REQ));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] kb(input logic [2:0] x);
        return (x == 3'h0) ? 8'h00 : 8'h04 << (x - 3'h1);
    endfunction
    // {ddr, chip selects, host ram, host rom, denied}
    function logic [7:0] exp_sel(input logic [31:0] a, input logic pg);
        logic [31:0] o;
        o = a - 32'h4200_0000;
        if (a >= 32'h8000_0000 && a <= 32'h8FFF_FFFF) return 8'h80;
        if (a >= 32'h4200_0000 && a <= 32'h49FF_FFFF) return pg ? 8'h01 : {1'b0, 4'h1 << o[26:25], 3'h0};
        if (a >= HOST_RAM_BASE && a < HOST_RAM_BASE + 32'h8000) return 8'h04;
        if (a >= HOST_ROM_BASE && a < HOST_ROM_BASE + 32'h2000) return 8'h02;
        return 8'h01;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= dat;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1 && n < 50) begin
            @(posedge CLK);
            n++;
        end
        if (n == 50) bad_count++;
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r & m, exp);
    endtask
    task settle();
        repeat (3) @(posedge CLK);
        #1;
    endtask
    task do_reset(input logic pin);
        RESET_N <= 1'b0;
        BOOT_SELECT_PIN <= pin;
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        settle();
        settle();
    endtask
    task finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // clock, watchdog and sequence
    // ---------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RESET_N, BOOT_SELECT_PIN} = '0;
        do_reset(1'b0);
        chk({BOOT_MODE_SELF, DSP_RESET_N}, 32'h0);
        apb(1'b1, OFS_SS_CTRL, 32'h3);
        settle();
        chk({DSP_RESET_N, DSP_CLK_EN}, 32'h3);
        apb(1'b1, OFS_SS_CTRL, 32'h1B);
        settle();
        chk({CLK_SRC_BYPASS, CPU_SLEEP, MEM_SLEEP, DSP_CLK_EN}, 32'hE);
        rd(OFS_IRQ_STATUS, 32'h2, 32'h2);
        apb(1'b1, OFS_SS_CTRL, 32'h65);
        #1 chk(DSP_BOOT_START, 32'h1);
        settle();
        chk({DSP_RESET_N, CPU_SLEEP, MEM_SLEEP}, 32'h3);
        rd(OFS_SS_STATUS, 32'hFF, 32'h22);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        far_u.raise_int();
        settle();
        chk(HOST_IRQ, 32'h1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        settle();
        chk(HOST_IRQ, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        far_u.raise_int();
        settle();
        chk(HOST_IRQ, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
        for (int i = 0; i < 6; i++) begin
            v = rnd() & 32'h1F;
            apb(1'b1, OFS_HOST2DSP, v);
            #1;
            chk({DSP_NMI, DSP_GEN_INT}, v);
        end
        {p, d, l} = '0;
        for (int i = 0; i < 14; i++) begin
            v = (i == 0) ? 32'h777 : (i == 1) ? 32'h644 : rnd() & 32'h777;
            if (v[2:0] <= 3'h4) p = v[2:0];
            if (v[6:4] <= 3'h3) d = v[6:4];
            if (v[10:8] <= 3'h6) l = v[10:8];
            apb(1'b1, OFS_CACHE_CFG, v);
            rd(OFS_CACHE_CFG, 32'h777, {l, 1'b0, d, 1'b0, p});
            chk({L2_CACHE_CFG, L1D_CACHE_CFG, L1P_CACHE_CFG}, {l, d, p});
            rd(OFS_CACHE_KB, 32'hFF_FFFF, {kb(l), kb(d), kb(p)});
        end
        apb(1'b0, 32'h100, 32'h0);
        chk(e, 32'h1);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            v = (i < 8) ? cor[i] : {cor[r[2:0]][31:25], r[24:0]};
            far_u.access(v, r[31]);
            #1;
            chk({DDR_SEL, ASYNC_CHIP_SELECT, HOST_RAM_SEL, HOST_ROM_SEL, DSP_ACC_DENIED}, exp_sel(v, r[31]));
        end
        rd(OFS_IRQ_STATUS, 32'h4, 32'h4);
        do_reset(1'b1);
        chk({BOOT_MODE_SELF, DSP_RESET_N, DSP_CLK_EN}, 32'h7);
        finish_test();
    end
endmodule // dsb_top_tb
